//--- serial_bus_pkg.sv
// Package holding register map, vector layout and carrier types of the quad serial bus interface
package serial_bus_pkg;

  // ****************************************
  // Address decode
  // ****************************************
  localparam int ADDR_W = 16;            // Bus address width
  localparam int BASE_LO = 5;            // Lowest base-compared address bit
  localparam int BASE_HI = 12;           // Highest base-compared address bit
  localparam int BASE_W = BASE_HI - BASE_LO + 1;
  localparam int CHAN_LO = 3;            // Channel select bits 4:3
  localparam int REG_LO = 1;             // Register select bits 2:1
  localparam logic [2:0] PAGE_TOP = 3'h7; // Address bits 15:13 of the upper peripheral page
  localparam logic [ADDR_W-1:0] CONSOLE_ADDR = 16'hff70; // Console block at octal 177560
  localparam logic [ADDR_W-1:0] CONSOLE_MASK = 16'hfff8; // Four word registers at the console block

  // Register select codes
  localparam logic [1:0] SEL_RX_CTRL = 2'h0;
  localparam logic [1:0] SEL_RX_BUF = 2'h1;
  localparam logic [1:0] SEL_TX_CTRL = 2'h2;
  localparam logic [1:0] SEL_TX_BUF = 2'h3;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CS_DONE = 7;            // Receiver done
  localparam int CS_IE = 6;              // Receiver interrupt enable
  localparam int CS_ADV = 0;             // Reader advance, write only
  localparam int RB_ERR = 15;            // Error summary
  localparam int RB_OVR = 14;            // Overrun
  localparam int RB_FRM = 13;            // Framing error
  localparam int RB_PAR = 12;            // Parity error

  // ****************************************
  // Vectors
  // ****************************************
  localparam int VEC_W = 9;              // Vector bits 8:0
  localparam int VEC_BASE_LO = 5;        // Base vector bits 8:5
  localparam int VEC_CH_LO = 3;          // Channel bits 4:3
  localparam int VEC_TX_BIT = 2;         // 0 receiver, 1 transmitter
  localparam logic [VEC_W-1:0] CONSOLE_RX_VEC = 9'h030; // Octal 60
  localparam logic [VEC_W-1:0] CONSOLE_TX_VEC = 9'h034; // Octal 64

  localparam int NCHAN = 4;

  // Character handed over by one receive framer
  typedef struct packed {
    logic done;        // One-cycle pulse, character complete
    logic frame_err;   // No valid stop bit
    logic parity_err;  // Parity mismatch
    logic [7:0] data;  // Right-justified data
  } rx_char_t;

  // Per-channel data format straps
  typedef struct packed {
    logic [1:0] bits_sel; // 0..3 gives 5..8 data bits
    logic parity_on;      // Parity checked
  } rx_format_t;

  // Decoded bus access
  typedef struct packed {
    logic hit;
    logic [1:0] chan;
    logic [1:0] sel;
  } decode_t;

endpackage

//--- bus_addr_decode.sv
// Address decoder mapping a bus address onto a channel and register
`timescale 1ns/1ps
module bus_addr_decode (
  // Address and straps
  input wire logic [serial_bus_pkg::ADDR_W-1:0] addr,
  input wire logic [serial_bus_pkg::BASE_W-1:0] base_addr,
  input wire logic console_mode,
  // Result
  output serial_bus_pkg::decode_t dec
);
  import serial_bus_pkg::*;

  // ****************************************
  // Decode
  // ****************************************
  // Console block checked first so channel 4 moves there cleanly
  always_comb begin
    dec = '0;
    if (console_mode && ((addr & CONSOLE_MASK) == CONSOLE_ADDR)) begin
      dec.hit = 1'b1;
      dec.chan = 2'h3;
      dec.sel = addr[REG_LO+:2];
    end else if ((addr[ADDR_W-1:BASE_HI+1] == PAGE_TOP) && (addr[BASE_HI:BASE_LO] == base_addr)) begin
      // Channel 4 slot is empty in console mode, block shrinks to 12
      if (!(console_mode && (addr[CHAN_LO+:2] == 2'h3))) begin
        dec.hit = 1'b1;
        dec.chan = addr[CHAN_LO+:2];
        dec.sel = addr[REG_LO+:2];
      end
    end
  end

endmodule

//--- irq_priority_encoder.sv
// Fixed priority encoder over the eight interrupt request lines
`timescale 1ns/1ps
module irq_priority_encoder (
  // Requests, bit 7 highest (ch4 rx) down to bit 0 (ch1 tx)
  input wire logic [7:0] req,
  // Winner
  output logic any,
  output logic [2:0] level
);

  // ****************************************
  // Encode
  // ****************************************
  // Highest set index wins; loop runs upward so last hit sticks
  always_comb begin
    any = |req;
    level = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (req[i]) begin
        level = 3'(i);
      end
    end
  end

endmodule

//--- quad_serial_line_bus_interface.sv
// Bus-side register, decode and interrupt logic of the four channel serial line interface
`timescale 1ns/1ps

module quad_serial_line_bus_interface #(
  parameter int NCH = 4 // Channel count, fixed by the decode layout
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Bus control, asynchronous to our clock
  input wire logic bus_sync,              // Address phase strobe
  input wire logic bus_din,               // Read data strobe
  input wire logic bus_dout,              // Write data strobe
  input wire logic interrupt_ack_in,      // Interrupt acknowledge daisy chain in
  input wire logic power_good_low,        // Power-good, low when bad
  input wire logic bus_initialize_high,   // Bus initialize
  input wire logic [serial_bus_pkg::ADDR_W-1:0] bus_dal_in,
  // Bus outputs
  output logic [serial_bus_pkg::ADDR_W-1:0] bus_dal_out,
  output logic bus_dal_oe,
  output logic bus_reply,
  output logic bus_irq,
  output logic interrupt_ack_out,
  // Straps
  input wire logic [serial_bus_pkg::BASE_W-1:0] base_addr,
  input wire logic [3:0] base_vector,
  input wire logic console_mode,
  input wire logic reset_from_init,       // 1: master reset follows initialize, 0: power-good
  input wire serial_bus_pkg::rx_format_t [3:0] rx_format,
  // UART side
  input wire serial_bus_pkg::rx_char_t [3:0] rx_char,
  input wire logic [3:0] tx_ready,        // Transmitter ready per channel
  input wire logic [3:0] tx_int_enable,   // Transmitter interrupt enable per channel
  output logic [3:0] reader_advance,      // One-cycle pulse per channel
  output logic uart_master_reset,
  output logic [1:0] access_chan,         // Channel of a transmitter register access
  output logic access_tx_ctrl,            // Transmitter register access decoded
  output logic access_tx_buf
);
  import serial_bus_pkg::*;

  initial begin
    if (NCH != NCHAN) begin
      $error("Channel count must be four");
    end
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  localparam int NPIN = 6;
  logic [NPIN-1:0] pin_meta_reg; // First stage, read only by second
  logic [NPIN-1:0] pin_sync_reg; // Second stage
  logic [ADDR_W-1:0] dal_meta_reg;
  logic [ADDR_W-1:0] dal_sync_reg;
  logic sync_s, din_s, dout_s, iack_s, pgood_low_s, init_s;

  // Two flops on every bus line
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
      dal_meta_reg <= '0;
      dal_sync_reg <= '0;
    end else begin
      pin_meta_reg <= {bus_sync, bus_din, bus_dout, interrupt_ack_in, power_good_low, bus_initialize_high};
      pin_sync_reg <= pin_meta_reg;
      dal_meta_reg <= bus_dal_in;
      dal_sync_reg <= dal_meta_reg;
    end
  end
  assign {sync_s, din_s, dout_s, iack_s, pgood_low_s, init_s} = pin_sync_reg;

  // ****************************************
  // Master reset select
  // ****************************************
  // Registered so the strap mux never glitches onto the UARTs
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      uart_master_reset <= 1'b1;
    end else begin
      uart_master_reset <= reset_from_init ? init_s : !pgood_low_s;
    end
  end

  // ****************************************
  // Address phase
  // ****************************************
  logic sync_d_reg;               // Previous synced strobe, for edge
  logic [ADDR_W-1:0] addr_reg;    // Address latched at strobe rise
  decode_t dec_now;
  decode_t dec_reg;               // Decode held for the data phase

  bus_addr_decode u_decode (
    .addr(dal_sync_reg),
    .base_addr(base_addr),
    .console_mode(console_mode),
    .dec(dec_now)
  );

  // Latch address and decode on strobe rise, drop the decode when strobe falls
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sync_d_reg <= 1'b0;
      addr_reg <= '0;
      dec_reg <= '0;
    end else begin
      sync_d_reg <= sync_s;
      if (sync_s && !sync_d_reg) begin
        addr_reg <= dal_sync_reg;
        dec_reg <= dec_now;
      end else if (!sync_s) begin
        dec_reg <= '0;
      end
    end
  end

  // ****************************************
  // Data phase strobes
  // ****************************************
  logic din_d_reg, dout_d_reg;
  logic rd_pulse, wr_pulse;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      din_d_reg <= 1'b0;
      dout_d_reg <= 1'b0;
    end else begin
      din_d_reg <= din_s;
      dout_d_reg <= dout_s;
    end
  end
  // Read strobe during an acknowledge cycle is the vector read, not a register read
  assign rd_pulse = din_s && !din_d_reg && dec_reg.hit && !iack_s;
  assign wr_pulse = dout_s && !dout_d_reg && dec_reg.hit;

  assign access_chan = dec_reg.chan;
  assign access_tx_ctrl = dec_reg.hit && (dec_reg.sel == SEL_TX_CTRL);
  assign access_tx_buf = dec_reg.hit && (dec_reg.sel == SEL_TX_BUF);

  // ****************************************
  // Receiver registers per channel
  // ****************************************
  logic [3:0] rx_done_reg;
  logic [3:0] rx_ie_reg;
  logic [3:0] ovr_reg, frm_reg, par_reg;
  logic [7:0] rx_data_reg [4];
  logic [3:0] adv_next;

  // Mask of valid data bits for a 5..8 bit character
  function automatic logic [7:0] data_mask(input logic [1:0] bits_sel);
    data_mask = 8'hff >> (2'h3 - bits_sel);
  endfunction

  for (genvar c = 0; c < NCHAN; c++) begin : g_chan
    logic sel_ch;
    logic wr_ctrl, rd_buf;
    assign sel_ch = (dec_reg.chan == 2'(c));
    assign wr_ctrl = wr_pulse && sel_ch && (dec_reg.sel == SEL_RX_CTRL);
    assign rd_buf = rd_pulse && sel_ch && (dec_reg.sel == SEL_RX_BUF);
    assign adv_next[c] = wr_ctrl && dal_sync_reg[CS_ADV];

    // Done: a new character wins over a clear in the same cycle
    always_ff @(posedge clock) begin
      if (!rst_n || init_s) begin
        rx_done_reg[c] <= 1'b0;
      end else if (rx_char[c].done) begin
        rx_done_reg[c] <= 1'b1;
      end else if (adv_next[c] || rd_buf) begin
        rx_done_reg[c] <= 1'b0;
      end
    end

    // Interrupt enable
    always_ff @(posedge clock) begin
      if (!rst_n || init_s) begin
        rx_ie_reg[c] <= 1'b0;
      end else if (wr_ctrl) begin
        rx_ie_reg[c] <= dal_sync_reg[CS_IE];
      end
    end

    // Data and error flags refresh only with a new character
    always_ff @(posedge clock) begin
      if (!rst_n || init_s) begin
        ovr_reg[c] <= 1'b0;
        frm_reg[c] <= 1'b0;
        par_reg[c] <= 1'b0;
        rx_data_reg[c] <= '0;
      end else if (rx_char[c].done) begin
        ovr_reg[c] <= rx_done_reg[c];
        frm_reg[c] <= rx_char[c].frame_err;
        par_reg[c] <= rx_char[c].parity_err && rx_format[c].parity_on;
        rx_data_reg[c] <= rx_char[c].data & data_mask(rx_format[c].bits_sel);
      end
    end
  end

  // Advance pulse lasts one clock
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      reader_advance <= '0;
    end else begin
      reader_advance <= adv_next;
    end
  end

  // ****************************************
  // Interrupt requests and arbitration
  // ****************************************
  logic [7:0] rq_reg;             // Source request lines
  logic [3:0] rx_done_d_reg, tx_ready_d_reg;
  logic [7:0] rq_set;
  logic [7:0] rq_clr;
  logic any_rq;
  logic [2:0] win_level;
  logic [2:0] grant_reg;          // Level latched at acknowledge
  logic ack_d_reg;
  logic ack_rise;

  assign ack_rise = iack_s && !ack_d_reg;

  // Requests: receivers take 7..4, transmitters 3..0, higher channel higher
  for (genvar c = 0; c < NCHAN; c++) begin : g_rq
    assign rq_set[c + NCHAN] = rx_done_reg[c] && !rx_done_d_reg[c] && rx_ie_reg[c];
    assign rq_set[c] = tx_ready[c] && !tx_ready_d_reg[c] && tx_int_enable[c];
  end
  for (genvar i = 0; i < 8; i++) begin : g_clr
    assign rq_clr[i] = ack_rise && any_rq && (win_level == 3'(i));
  end

  // Request line set on rising done or ready, cleared by its acknowledge or loss of enable
  always_ff @(posedge clock) begin
    if (!rst_n || init_s) begin
      rq_reg <= '0;
      rx_done_d_reg <= '0;
      tx_ready_d_reg <= '0;
    end else begin
      rx_done_d_reg <= rx_done_reg;
      tx_ready_d_reg <= tx_ready;
      rq_reg <= ((rq_reg & ~rq_clr) | rq_set) &
                {rx_ie_reg, tx_int_enable};
    end
  end

  irq_priority_encoder u_prio (
    .req(rq_reg),
    .any(any_rq),
    .level(win_level)
  );

  // Latch the winner at acknowledge so the vector stays stable
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ack_d_reg <= 1'b0;
      grant_reg <= '0;
    end else begin
      ack_d_reg <= iack_s;
      if (ack_rise && any_rq) begin
        grant_reg <= win_level;
      end
    end
  end

  logic granted_reg; // We own the current acknowledge cycle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      granted_reg <= 1'b0;
    end else if (ack_rise) begin
      granted_reg <= any_rq;
    end else if (!iack_s) begin
      granted_reg <= 1'b0;
    end
  end

  // Request out; acknowledge passed on when we have nothing pending
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      bus_irq <= 1'b0;
      interrupt_ack_out <= 1'b0;
    end else begin
      bus_irq <= any_rq;
      interrupt_ack_out <= iack_s && !granted_reg && !(ack_rise && any_rq);
    end
  end

  // ****************************************
  // Vector build
  // ****************************************
  function automatic logic [VEC_W-1:0] make_vector(input logic [2:0] lvl, input logic [3:0] base,
                                                   input logic console);
    logic is_tx;
    logic [1:0] ch;
    is_tx = !lvl[2];
    ch = lvl[1:0];
    if (console && ch == 2'h3) begin
      make_vector = is_tx ? CONSOLE_TX_VEC : CONSOLE_RX_VEC;
    end else begin
      make_vector = '0;
      make_vector[VEC_BASE_LO+:4] = base;
      make_vector[VEC_CH_LO+:2] = ch;
      make_vector[VEC_TX_BIT] = is_tx;
    end
  endfunction

  // ****************************************
  // Read data and reply
  // ****************************************
  logic [ADDR_W-1:0] rd_word;
  logic [1:0] rc;
  assign rc = dec_reg.chan;

  always_comb begin
    rd_word = '0;
    if (dec_reg.sel == SEL_RX_CTRL) begin
      rd_word[CS_DONE] = rx_done_reg[rc];
      rd_word[CS_IE] = rx_ie_reg[rc];
    end else if (dec_reg.sel == SEL_RX_BUF) begin
      rd_word[RB_ERR] = ovr_reg[rc] | frm_reg[rc] | par_reg[rc];
      rd_word[RB_OVR] = ovr_reg[rc];
      rd_word[RB_FRM] = frm_reg[rc];
      rd_word[RB_PAR] = par_reg[rc];
      rd_word[7:0] = rx_data_reg[rc];
    end
  end

  // Drive data on a register read or a granted vector cycle; reply with it
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      bus_dal_out <= '0;
      bus_dal_oe <= 1'b0;
      bus_reply <= 1'b0;
    end else if (granted_reg && din_s) begin
      bus_dal_out <= ADDR_W'(make_vector(grant_reg, base_vector, console_mode));
      bus_dal_oe <= 1'b1;
      bus_reply <= 1'b1;
    end else if (dec_reg.hit && din_s && !iack_s) begin
      bus_dal_out <= rd_word;
      bus_dal_oe <= 1'b1;
      bus_reply <= 1'b1;
    end else begin
      bus_dal_out <= '0;
      bus_dal_oe <= 1'b0;
      bus_reply <= dec_reg.hit && dout_s;
    end
  end

endmodule

//--- quad_serial_line_bus_interface_properties.sv
// Port-level assertions of the quad serial line bus interface
`timescale 1ns/1ps
module quad_serial_line_bus_interface_properties #(
  parameter int NCH = 4 // Channel count
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Bus side
  input wire logic bus_din,
  input wire logic bus_dout,
  input wire logic interrupt_ack_in,
  input wire logic power_good_low,
  input wire logic bus_initialize_high,
  input wire logic [15:0] bus_dal_out,
  input wire logic bus_dal_oe,
  input wire logic bus_reply,
  input wire logic bus_irq,
  input wire logic interrupt_ack_out,
  // Straps
  input wire logic [3:0] base_vector,
  input wire logic console_mode,
  input wire logic reset_from_init,
  // UART side
  input wire logic [3:0] reader_advance,
  input wire logic uart_master_reset,
  input wire logic access_tx_ctrl,
  input wire logic access_tx_buf
);
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Five cycles cover two sync flops and the output flop
  chk_reset_quiet: assert property (disable iff (1'b0) !rst_n |=> !bus_reply && !bus_irq && uart_master_reset)
    else $error("reset levels wrong");
  chk_reset_source: assert property ((reset_from_init ? bus_initialize_high : !power_good_low) [*5] |-> uart_master_reset)
    else $error("master reset missed");
  chk_reset_other: assert property (((reset_from_init ? !bus_initialize_high : power_good_low) && $stable(reset_from_init)) [*5]
    |-> !uart_master_reset)
    else $error("reset from wrong source");
  chk_reply_cause: assert property ($rose(bus_reply) |-> bus_din || bus_dout)
    else $error("reply without strobe");
  chk_reply_release: assert property ($fell(bus_din) && !bus_dout |-> ##[1:5] !bus_reply)
    else $error("reply held after strobe");
  chk_write_no_drive: assert property (bus_dal_oe |-> !bus_dout)
    else $error("data driven in write");
  // Passed acknowledge lags its pin by three flops
  chk_ack_passed: assert property (interrupt_ack_out |-> $past(interrupt_ack_in, 3))
    else $error("stray acknowledge out");
  chk_ack_ours: assert property ($rose(bus_reply) && interrupt_ack_in |-> !interrupt_ack_out)
    else $error("ack passed on while ours");
  chk_vector_range: assert property (bus_dal_oe && interrupt_ack_in |-> bus_dal_out[15:9] == 7'h0 && bus_dal_out[1:0] == 2'h0)
    else $error("vector out of range");
  chk_vector_base: assert property (bus_dal_oe && interrupt_ack_in && !console_mode |-> bus_dal_out[8:5] == base_vector)
    else $error("vector base bits wrong");
  chk_advance_pulse: assert property (|reader_advance |-> $onehot(reader_advance) ##1 reader_advance == 4'h0)
    else $error("advance not a single pulse");
  chk_tx_select: assert property (!(access_tx_ctrl && access_tx_buf))
    else $error("two tx selects");
  // Main scenarios reached
  cover property (bus_irq && $rose(interrupt_ack_in));
  cover property ($rose(bus_reply) && bus_dout);
  cover property (|reader_advance);
endmodule

bind quad_serial_line_bus_interface quad_serial_line_bus_interface_properties #(.NCH(NCH)) i_props (.clock, .rst_n,
  .bus_din, .bus_dout, .interrupt_ack_in, .power_good_low, .bus_initialize_high, .bus_dal_out, .bus_dal_oe,
  .bus_reply, .bus_irq, .interrupt_ack_out, .base_vector, .console_mode, .reset_from_init, .reader_advance,
  .uart_master_reset, .access_tx_ctrl, .access_tx_buf);

//--- host_bus_model.sv
// Host processor model issuing read, write and acknowledge cycles on the parallel bus
`timescale 1ns/1ps
module host_bus_model (
  // Clock
  input wire logic clock,
  // Requests, idle from time zero
  output logic bus_sync = 1'b0,
  output logic bus_din = 1'b0,
  output logic bus_dout = 1'b0,
  output logic interrupt_ack_in = 1'b0,
  output logic [15:0] bus_dal_in = 16'h0,
  // Answers
  input wire logic bus_reply,
  input wire logic [15:0] bus_dal_out
);
  // Kind 0 read, 1 write, 2 acknowledge; strobes held until reply or 12 clocks
  task automatic cycle(input int k, input logic [15:0] a, input logic [15:0] w, output logic [15:0] d,
                       output logic ok);
    int n;
    @(posedge clock);
    if (k == 2) begin
      interrupt_ack_in <= 1'b1;
    end else begin
      bus_sync <= 1'b1;
      bus_dal_in <= a;
    end
    // Let the address clear the sync flops first
    repeat (4) @(posedge clock);
    bus_dal_in <= (k == 1) ? w : ~a;
    if (k == 1) bus_dout <= 1'b1;
    else bus_din <= 1'b1;
    ok = 1'b0;
    for (n = 0; n < 12 && !ok; n++) begin
      @(posedge clock);
      ok = bus_reply;
    end
    d = bus_dal_out;
    bus_din <= 1'b0;
    bus_dout <= 1'b0;
    for (n = 0; n < 12 && bus_reply; n++) @(posedge clock);
    // Released lines show a new pattern
    bus_sync <= 1'b0;
    interrupt_ack_in <= 1'b0;
    bus_dal_in <= ~bus_dal_in;
    repeat (3) @(posedge clock);
  endtask
endmodule

//--- quad_serial_line_bus_interface_tb.sv
// Self-checking bench of the quad serial line bus interface
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin err_total++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module quad_serial_line_bus_interface_tb;
  import serial_bus_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic power_good_low = 1'b1;
  logic bus_initialize_high = 1'b0, ack_seen = 1'b0;
  logic bus_sync, bus_din, bus_dout, interrupt_ack_in, bus_dal_oe, bus_reply, bus_irq, interrupt_ack_out;
  logic uart_master_reset, access_tx_ctrl, access_tx_buf, ok;
  logic [15:0] bus_dal_in, bus_dal_out, d;
  logic [15:0] s = 16'h0051; // Fixed seed
  logic [7:0] base_addr = 8'hea; // Block at 176500
  logic [3:0] base_vector = 4'h6; // Vectors from 300
  logic console_mode = 1'b0;
  logic reset_from_init = 1'b1;
  rx_format_t [3:0] rx_format = '0;
  rx_char_t [3:0] rx_char = '0;
  logic [3:0] tx_ready = 4'h0;
  logic [3:0] tx_int_enable = 4'h0;
  logic [3:0] reader_advance, tx_seen;
  logic [1:0] access_chan;
  int adv_cnt [4];
  int err_total, check_count;
  always #4 clock = ~clock;
  quad_serial_line_bus_interface #(.NCH(4)) i_quad_serial_line_bus_interface (.clock, .rst_n, .bus_sync, .bus_din,
    .bus_dout, .interrupt_ack_in, .power_good_low, .bus_initialize_high, .bus_dal_in, .bus_dal_out, .bus_dal_oe,
    .bus_reply, .bus_irq, .interrupt_ack_out, .base_addr, .base_vector, .console_mode, .reset_from_init, .rx_format,
    .rx_char, .tx_ready, .tx_int_enable, .reader_advance, .uart_master_reset, .access_chan, .access_tx_ctrl,
    .access_tx_buf);
  host_bus_model host (.clock, .bus_sync, .bus_din, .bus_dout, .interrupt_ack_in, .bus_dal_in, .bus_reply,
    .bus_dal_out);
  // Count advances, note tx selects and passed acknowledges
  always @(posedge clock) begin
    for (int i = 0; i < 4; i++) adv_cnt[i] += reader_advance[i];
    if (interrupt_ack_out) ack_seen <= 1'b1;
    if (access_tx_ctrl || access_tx_buf) tx_seen <= {access_tx_ctrl, access_tx_buf, access_chan};
  end
  // ****************************************
  // Expectations
  // ****************************************
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [15:0] ad(input logic [1:0] c, input logic [1:0] r);
    if (console_mode && c == 2'h3) return 16'hff70 | {13'h0, r, 1'b0};
    return {3'h7, base_addr, c, r, 1'b0};
  endfunction
  // Vector of priority level l: receivers on 7..4
  function automatic logic [15:0] vec(input int l);
    return {7'h0, base_vector, l[1:0], l < 4, 2'h0};
  endfunction
  // Buffer word, parity flag masked when off
  function automatic logic [15:0] bufw(input logic [7:0] v, input rx_format_t f, input logic fe, pe, ov);
    logic p;
    p = pe & f.parity_on;
    return {ov | fe | p, ov, fe, p, 4'h0, v & (8'hff >> (2'h3 - f.bits_sel))};
  endfunction
  task automatic xf(input int k, input logic [15:0] a, input logic [15:0] w);
    host.cycle(k, a, w, d, ok);
  endtask
  task automatic rx_put(input logic [1:0] c, input logic [7:0] v, input logic fe, pe);
    @(posedge clock);
    rx_char[c] <= {1'b1, fe, pe, v};
    @(posedge clock);
    rx_char[c].done <= 1'b0;
    repeat (3) @(posedge clock);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Run takes under two thousand cycles
  initial begin
    repeat (30000) @(posedge clock);
    err_total++;
    summarize();
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    for (int c = 0; c < 8; c++) begin
      xf(0, ad(c[2:1], {1'b0, c[0]}), 16'h0);
      `CHK("reset word", 17'h10000, {ok, d})
    end
    // All bits written: only enable sticks, bit 0 pulses advance
    for (int c = 0; c < 4; c++) begin
      xf(1, ad(c[1:0], 2'h0), 16'hffff);
      xf(0, ad(c[1:0], 2'h0), 16'h0);
      `CHK("ctrl write", 16'h0040, d)
      `CHK("advance count", 1, adv_cnt[c])
    end
    // Random characters, channels and formats
    repeat (16) begin
      s = lfsr(s);
      rx_format[s[1:0]] <= s[4:2];
      rx_put(s[1:0], s[15:8], s[5], s[6]);
      xf(0, ad(s[1:0], 2'h0), 16'h0);
      `CHK("ctrl done", 16'h00c0, d)
      xf(0, ad(s[1:0], 2'h1), 16'h0);
      `CHK("buffer", bufw(s[15:8], s[4:2], s[5], s[6], 1'b0), d)
      xf(0, ad(s[1:0], 2'h0), 16'h0);
      `CHK("ctrl after read", 16'h0040, d)
    end
    // Second character lands on done; flags then hold
    rx_put(2'h1, 8'h5a, 1'b1, 1'b0);
    rx_put(2'h1, 8'ha5, 1'b0, 1'b0);
    repeat (2) begin
      xf(0, ad(2'h1, 2'h1), 16'h0);
      `CHK("overrun", bufw(8'ha5, rx_format[1], 1'b0, 1'b0, 1'b1), d)
    end
    rx_put(2'h1, 8'h3c, 1'b1, 1'b0);
    xf(0, ad(2'h1, 2'h1), 16'h0);
    `CHK("frame", bufw(8'h3c, rx_format[1], 1'b1, 1'b0, 1'b0), d)
    bus_initialize_high <= 1'b1;
    repeat (6) @(posedge clock);
    bus_initialize_high <= 1'b0;
    repeat (6) @(posedge clock);
    xf(0, ad(2'h1, 2'h0), 16'h0);
    `CHK("ctrl after init", 16'h0000, d)
    xf(0, ad(2'h1, 2'h1), 16'h0);
    `CHK("buffer after init", 16'h0000, d)
    // All eight sources pending, granted one at a time
    for (int c = 0; c < 4; c++) xf(1, ad(c[1:0], 2'h0), 16'h0040);
    tx_int_enable <= 4'hf;
    for (int c = 0; c < 4; c++) rx_put(c[1:0], 8'h11, 1'b0, 1'b0);
    tx_ready <= 4'hf;
    repeat (4) @(posedge clock);
    for (int l = 7; l >= 0; l--) begin
      `CHK("request", 1'b1, bus_irq)
      xf(2, 16'h0, 16'h0);
      `CHK("vector", vec(l), d)
    end
    `CHK("requests drained", 1'b0, bus_irq)
    `CHK("ack kept", 1'b0, ack_seen)
    xf(2, 16'h0, 16'h0);
    `CHK("ack passed", 2'h1, {ok, ack_seen})
    // Console mode: channel 4 moves and uses fixed vectors
    console_mode <= 1'b1;
    tx_ready <= 4'h0;
    repeat (4) @(posedge clock);
    xf(0, ad(2'h3, 2'h1), 16'h0);
    `CHK("console reply", 1'b1, ok)
    xf(0, {3'h7, base_addr, 5'h18}, 16'h0);
    `CHK("base slot gone", 1'b0, ok)
    rx_put(2'h3, 8'h22, 1'b0, 1'b0);
    tx_ready <= 4'h8;
    repeat (4) @(posedge clock);
    xf(2, 16'h0, 16'h0);
    `CHK("console rx vector", 16'h0030, d)
    xf(2, 16'h0, 16'h0);
    `CHK("console tx vector", 16'h0034, d)
    console_mode <= 1'b0;
    // Foreign addresses, block at 40, transmitter registers
    xf(0, {3'h7, ~base_addr, 5'h0}, 16'h0);
    `CHK("base mismatch", 1'b0, ok)
    xf(0, {3'h6, base_addr, 5'h0}, 16'h0);
    `CHK("outside page", 1'b0, ok)
    base_addr <= 8'heb;
    @(posedge clock);
    xf(0, ad(2'h0, 2'h0), 16'h0);
    `CHK("block at 40", 1'b1, ok)
    xf(0, ad(2'h2, 2'h2), 16'h0);
    `CHK("tx ctrl read", 16'h0000, d)
    `CHK("tx ctrl select", 4'ha, tx_seen)
    xf(1, ad(2'h1, 2'h3), 16'h0055);
    `CHK("tx buf select", 4'h5, tx_seen)
    // Master reset follows power-good once selected
    reset_from_init <= 1'b0;
    power_good_low <= 1'b0;
    repeat (6) @(posedge clock);
    `CHK("reset on power", 1'b1, uart_master_reset)
    power_good_low <= 1'b1;
    bus_initialize_high <= 1'b1;
    repeat (6) @(posedge clock);
    `CHK("init ignored", 1'b0, uart_master_reset)
    bus_initialize_high <= 1'b0;
    summarize();
  end
endmodule
